/* File: core/asc_top.sv */
// Conversion sequencer with a classic Wishbone register slave.
//
// Overview of operation
// - End-of-conversion flag sets on each finished conversion, clears on high byte read.
// - Software start bit starts a sequence when selected and idle; clears at sequence end.
// - Start source picks pin edge, previous sequence end, timer compare or software bit.
// - Start codes: 00 pin, 01 free running, 10 timer compare, 11 software bit.
// - Decimation codes 00..11 give rates 64,128,256,512 with 7,9,10,12 bits.
// - End codes 0-7 single-ended from input 0, 8-11 pairs, higher one conversion.
// - Disabled inputs are skipped; a pair needs both pins enabled.
// - Writing the extra register runs one conversion now or after the running sequence.
// - Extra register holds input, reference and rate coded like the sequence fields.
// - A sequence with no enabled inputs still updates channel readback and done flag.
// - Reference choices: internal 1.25 V, supply, input 7, or pair 6-7.
// - Results are two's complement; single-ended 0..2047, differential -2048..2047.
// - Results are left-justified in the high and low result bytes.
// - Channel readback gives written end code plus one below 1100, else the code.
// - After an extra conversion the channel readback holds the extra channel code.
// - Converter clock is the system clock divided by six.
// - A conversion lasts 16 settling periods plus the decimation rate.
// - Interrupt fires only when an extra conversion completes.
// - Per-channel DMA triggers 20 to 28 pulse on each sequence result, not on extra conversion results.
// - DMA triggers 27 and 28 are shared with the audio serial interface.
// - Any-conversion trigger pulses on sequence results; extra conversions fire no trigger.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        external_trigger_pin_i,
    input  wire logic        timer1_ch0_compare_i,
    input  wire logic [1:0]  i2s_dma_req_i,
    input  wire logic [11:0] mod_result_i,
    output logic      [3:0]  mux_channel_o,
    output logic      [1:0]  reference_select_o,
    output logic      [1:0]  decimation_select_o,
    output logic             conv_start_o,
    output logic             conv_busy_o,
    output logic             adc_clk_en_o,
    output logic             irq_o,
    output logic      [8:0]  dma_trigger_o,
    output logic             any_conversion_trigger_o
);
    import asc_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    asc_pkg::asc_state_t state_ff;
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic [1:0]  start_source_select_ff;
    logic [1:0]  reference_select_ff;
    logic [1:0]  decimation_select_ff;
    logic [3:0]  sch_wr_ff;
    logic [3:0]  sequence_end_channel_ff;
    logic [1:0]  extra_ref_ff;
    logic [1:0]  extra_div_ff;
    logic [3:0]  extra_channel_select_ff;
    logic [7:0]  analog_input_enable_ff;
    logic        sequence_start_bit_ff;
    logic        eoc_ff;
    logic [11:0] result_ff;
    logic        extra_pend_ff;
    logic        is_extra_ff;
    logic        any_conv_ff;
    logic [3:0]  cur_ch_ff;
    logic [3:0]  end_ch_ff;
    logic [3:0]  conv_ch_ff;
    logic [1:0]  conv_ref_ff;
    logic [1:0]  conv_div_ff;
    logic        timer_start_ff;
    logic [2:0]  pin_sync_ff;
    logic        irq_ff;
    logic [8:0]  dma_ff;
    logic        any_trig_ff;
    logic        timer_done;
    logic        timer_busy;
    logic        timer_clk_en;
    logic        bus_req;
    logic        bus_acc;
    logic        bus_wr;
    logic [9:0]  bus_idx;
    logic        ext_rise;
    logic        start_evt;
    logic        conv_fin;
    logic        seq_fin;
    logic [7:0]  rd_byte;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Tells whether a channel code may be converted given the enabled inputs.
    function automatic logic ch_enabled(input logic [3:0] ch, input logic [7:0] en);
        if (ch < `ASC_SCH_DIFF) begin
            ch_enabled = en[ch[2:0]];
        end else if (ch < `ASC_SCH_SINGLE) begin
            ch_enabled = en[{ch[1:0], 1'b0}] & en[{ch[1:0], 1'b1}];
        end else begin
            ch_enabled = 1'b1;
        end
    endfunction

    // First channel of a sequence for a given end code.
    function automatic logic [3:0] first_ch(input logic [3:0] sequence_end_channel);
        if (sequence_end_channel < `ASC_SCH_DIFF) begin
            first_ch = 4'h0;
        end else if (sequence_end_channel < `ASC_SCH_SINGLE) begin
            first_ch = `ASC_SCH_DIFF;
        end else begin
            first_ch = sequence_end_channel;
        end
    endfunction

    // Left-justifies a right-aligned result of the rate's resolution.
    function automatic logic [11:0] justify(input logic [11:0] raw, input logic [1:0] d);
        case (d)
            2'h0:    justify = {raw[6:0], 5'h00};
            2'h1:    justify = {raw[8:0], 3'h0};
            2'h2:    justify = {raw[9:0], 2'h0};
            default: justify = raw;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------

    // A request is acknowledged one cycle after it appears; it acts at the ack edge.
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_acc = bus_req & ack_ff;
    assign bus_wr  = bus_acc & wb_we_i & wb_sel_i[0];
    assign bus_idx = wb_adr_i[11:2];

    // Read multiplexer; unmapped indices read as zero.
    always_comb begin
        case (bus_idx)
            `ASC_IDX_CTRL1:     rd_byte = {eoc_ff, sequence_start_bit_ff,
                                           start_source_select_ff, 2'h0, `ASC_CTRL1_RSVD};
            `ASC_IDX_SEQ_CFG:   rd_byte = {reference_select_ff, decimation_select_ff,
                                           sequence_end_channel_ff};
            `ASC_IDX_EXTRA_CFG: rd_byte = {extra_ref_ff, extra_div_ff, extra_channel_select_ff};
            `ASC_IDX_RES_LOW:   rd_byte = {result_ff[3:0], 4'h0};
            `ASC_IDX_RES_HIGH:  rd_byte = result_ff[11:4];
            `ASC_IDX_AIN_EN:    rd_byte = analog_input_enable_ff;
            default:            rd_byte = 8'h00;
        endcase
    end

    // Registered acknowledge and read data.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
            if (bus_req && !ack_ff) begin
                dat_ff <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Software-written fields of the control, sequence, extra and enable registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_source_select_ff  <= `ASC_START_SOURCE_SELECT_RST;
            reference_select_ff     <= `ASC_REFERENCE_SELECT_RST;
            decimation_select_ff    <= `ASC_DECIMATION_SELECT_RST;
            sch_wr_ff               <= `ASC_SCH_RST;
            extra_ref_ff            <= `ASC_REFERENCE_SELECT_RST;
            extra_div_ff            <= 2'h0;
            extra_channel_select_ff <= `ASC_SCH_RST;
            analog_input_enable_ff  <= `ASC_AIN_EN_RST;
        end else if (bus_wr) begin
            case (bus_idx)
                `ASC_IDX_CTRL1: start_source_select_ff <= wb_dat_i[5:4];
                `ASC_IDX_SEQ_CFG: begin
                    reference_select_ff  <= wb_dat_i[7:6];
                    decimation_select_ff <= wb_dat_i[5:4];
                    sch_wr_ff            <= wb_dat_i[3:0];
                end
                `ASC_IDX_EXTRA_CFG: begin
                    extra_ref_ff            <= wb_dat_i[7:6];
                    extra_div_ff            <= wb_dat_i[5:4];
                    extra_channel_select_ff <= wb_dat_i[3:0];
                end
                `ASC_IDX_AIN_EN: analog_input_enable_ff <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Start sources
    // ------------------------------------------------------------------

    // Two-stage synchroniser on the trigger pin, then a rising edge detect.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_ff <= 3'h0;
        end else begin
            pin_sync_ff <= {pin_sync_ff[1:0], external_trigger_pin_i};
        end
    end
    assign ext_rise = pin_sync_ff[1] & ~pin_sync_ff[2];

    // Start event chosen by the start source code.
    always_comb begin
        case (start_source_select_ff)
            `ASC_START_SOURCE_SELECT_EXT:   start_evt = ext_rise;
            `ASC_START_SOURCE_SELECT_FREE:  start_evt = 1'b1;
            `ASC_START_SOURCE_SELECT_TIMER: start_evt = timer1_ch0_compare_i;
            default:          start_evt = sequence_start_bit_ff;
        endcase
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    assign conv_fin = (state_ff == ASC_CONV) & timer_done;
    assign seq_fin  = (state_ff == ASC_FINISH);

    // Walks the channels of a sequence, or runs one extra conversion.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff       <= ASC_IDLE;
            cur_ch_ff      <= 4'h0;
            end_ch_ff      <= 4'h0;
            conv_ch_ff     <= 4'h0;
            conv_ref_ff    <= 2'h0;
            conv_div_ff    <= 2'h0;
            is_extra_ff    <= 1'b0;
            any_conv_ff    <= 1'b0;
            timer_start_ff <= 1'b0;
        end else begin
            timer_start_ff <= 1'b0;
            case (state_ff)
                ASC_IDLE: begin
                    if (extra_pend_ff) begin
                        conv_ch_ff     <= extra_channel_select_ff;
                        conv_ref_ff    <= extra_ref_ff;
                        conv_div_ff    <= extra_div_ff;
                        is_extra_ff    <= 1'b1;
                        timer_start_ff <= 1'b1;
                        state_ff       <= ASC_CONV;
                    end else if (start_evt) begin
                        cur_ch_ff   <= first_ch(sch_wr_ff);
                        end_ch_ff   <= sch_wr_ff;
                        is_extra_ff <= 1'b0;
                        any_conv_ff <= 1'b0;
                        state_ff    <= ASC_PICK;
                    end
                end
                ASC_PICK: begin
                    if (ch_enabled(cur_ch_ff, analog_input_enable_ff)) begin
                        conv_ch_ff     <= cur_ch_ff;
                        conv_ref_ff    <= reference_select_ff;
                        conv_div_ff    <= decimation_select_ff;
                        any_conv_ff    <= 1'b1;
                        timer_start_ff <= 1'b1;
                        state_ff       <= ASC_CONV;
                    end else if (cur_ch_ff == end_ch_ff) begin
                        state_ff <= ASC_FINISH;
                    end else begin
                        cur_ch_ff <= cur_ch_ff + 4'h1;
                    end
                end
                ASC_CONV: begin
                    if (timer_done) begin
                        if (is_extra_ff) begin
                            state_ff <= ASC_IDLE;
                        end else if (cur_ch_ff == end_ch_ff) begin
                            state_ff <= ASC_FINISH;
                        end else begin
                            cur_ch_ff <= cur_ch_ff + 4'h1;
                            state_ff  <= ASC_PICK;
                        end
                    end
                end
                ASC_FINISH: state_ff <= ASC_IDLE;
                default:    state_ff <= ASC_IDLE;
            endcase
        end
    end

    // Pending extra conversion; a new write wins over the take-up.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            extra_pend_ff <= 1'b0;
        end else if (bus_wr && bus_idx == `ASC_IDX_EXTRA_CFG) begin
            extra_pend_ff <= 1'b1;
        end else if (state_ff == ASC_IDLE) begin
            extra_pend_ff <= 1'b0;
        end
    end

    // Software start bit: written ones set it, sequence end clears it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sequence_start_bit_ff <= 1'b0;
        end else if (bus_wr && bus_idx == `ASC_IDX_CTRL1 && wb_dat_i[`ASC_ST_BIT]) begin
            sequence_start_bit_ff <= 1'b1;
        end else if (seq_fin) begin
            sequence_start_bit_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Results and status
    // ------------------------------------------------------------------

    // Result capture and conversion-done flag; a completion wins over a read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_ff <= 12'h000;
            eoc_ff    <= 1'b0;
        end else begin
            if (conv_fin) begin
                result_ff <= justify(mod_result_i, conv_div_ff);
            end
            if (conv_fin || (seq_fin && !any_conv_ff)) begin
                eoc_ff <= 1'b1;
            end else if (bus_acc && !wb_we_i && bus_idx == `ASC_IDX_RES_HIGH) begin
                eoc_ff <= 1'b0;
            end
        end
    end

    // Channel readback: written value, then the end code (plus one below 1100) after a sequence, or the extra channel.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sequence_end_channel_ff <= `ASC_SCH_RST;
        end else if (conv_fin && is_extra_ff) begin
            sequence_end_channel_ff <= conv_ch_ff;
        end else if (seq_fin) begin
            sequence_end_channel_ff <= (end_ch_ff < `ASC_SCH_SINGLE) ?
                                       end_ch_ff + 4'h1 : end_ch_ff;
        end else if (bus_wr && bus_idx == `ASC_IDX_SEQ_CFG) begin
            sequence_end_channel_ff <= wb_dat_i[3:0];
        end
    end

    // Interrupt on extra completion only; DMA triggers on sequence results and shared audio requests only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ff      <= 1'b0;
            dma_ff      <= 9'h000;
            any_trig_ff <= 1'b0;
        end else begin
            irq_ff      <= conv_fin & is_extra_ff;
            any_trig_ff <= conv_fin & ~is_extra_ff;
            dma_ff      <= {i2s_dma_req_i, 7'h00};
            if (conv_fin && !is_extra_ff) begin
                dma_ff <= {i2s_dma_req_i, 7'h00} |
                          (9'h001 << ((conv_ch_ff > `ASC_DMA_LAST) ?
                                      `ASC_DMA_LAST : conv_ch_ff));
            end
        end
    end

    // ------------------------------------------------------------------
    // Converter timing
    // ------------------------------------------------------------------

    // Divider and conversion length timer.
    asc_conv_timer u_timer (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .start_i      (timer_start_ff),
        .decim_i      (conv_div_ff),
        .adc_clk_en_o (timer_clk_en),
        .done_o       (timer_done),
        .busy_o       (timer_busy)
    );

    // Output drive; every output comes from a flip-flop.
    assign wb_dat_o                 = dat_ff;
    assign wb_ack_o                 = ack_ff;
    assign mux_channel_o            = conv_ch_ff;
    assign reference_select_o       = conv_ref_ff;
    assign decimation_select_o      = conv_div_ff;
    assign conv_start_o             = timer_start_ff;
    assign conv_busy_o              = timer_busy;
    assign adc_clk_en_o             = timer_clk_en;
    assign irq_o                    = irq_ff;
    assign dma_trigger_o            = dma_ff;
    assign any_conversion_trigger_o = any_trig_ff;

endmodule

/* File: core/asc_consts.svh */
// Register indices, field positions, reset values and timing counts of the sequencer.
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------------------
`define ASC_IDX_CTRL1      10'h0b4
`define ASC_IDX_SEQ_CFG    10'h0b5
`define ASC_IDX_EXTRA_CFG  10'h0b6
`define ASC_IDX_RES_LOW    10'h0ba
`define ASC_IDX_RES_HIGH   10'h0bb
`define ASC_IDX_AIN_EN     10'h0c0

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define ASC_EOC_BIT        7
`define ASC_ST_BIT         6
`define ASC_START_SOURCE_SELECT_RST      2'h3
`define ASC_CTRL1_RSVD     2'h3
`define ASC_REFERENCE_SELECT_RST       2'h0
`define ASC_DECIMATION_SELECT_RST       2'h1
`define ASC_SCH_RST        4'h0
`define ASC_AIN_EN_RST     8'h00

// ---------------------------------------------------------------------------
// Start source codes
// ---------------------------------------------------------------------------
`define ASC_START_SOURCE_SELECT_EXT      2'h0
`define ASC_START_SOURCE_SELECT_FREE     2'h1
`define ASC_START_SOURCE_SELECT_TIMER    2'h2
`define ASC_START_SOURCE_SELECT_SW       2'h3

// ---------------------------------------------------------------------------
// Channel code boundaries
// ---------------------------------------------------------------------------
`define ASC_SCH_DIFF       4'h8
`define ASC_SCH_SINGLE     4'hc
`define ASC_DMA_LAST       4'h8

// ---------------------------------------------------------------------------
// Timing: converter clock divider, settling periods, smallest decimation rate
// ---------------------------------------------------------------------------
`define ASC_CLK_DIV_LAST   3'h5
`define ASC_SETTLE         10'h010
`define ASC_RATE_BASE      10'h040

`endif

/* File: core/asc_pkg.sv */
// Types shared by the sequencer modules.
package asc_pkg;

    // Sequencer states.
    typedef enum logic [1:0] {
        ASC_IDLE   = 2'b00,
        ASC_PICK   = 2'b01,
        ASC_CONV   = 2'b10,
        ASC_FINISH = 2'b11
    } asc_state_t;

endpackage

/* File: core/asc_conv_timer.sv */
// Converter clock divider and conversion length timer.
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_conv_timer (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [1:0] decim_i,
    output logic            adc_clk_en_o,
    output logic            done_o,
    output logic            busy_o
);
    import asc_pkg::*;

    logic [2:0] div_ff;
    logic       en_ff;
    logic [9:0] cnt_ff;
    logic [9:0] len_ff;
    logic       busy_ff;
    logic       done_ff;

    // Conversion length: settling periods plus the decimation rate.
    function automatic logic [9:0] conv_len(input logic [1:0] d);
        conv_len = `ASC_SETTLE + (`ASC_RATE_BASE << d);
    endfunction

    // Free running divide-by-six enable for the converter clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= 3'h0;
            en_ff  <= 1'b0;
        end else begin
            en_ff  <= (div_ff == `ASC_CLK_DIV_LAST);
            div_ff <= (div_ff == `ASC_CLK_DIV_LAST) ? 3'h0 : div_ff + 3'h1;
        end
    end

    // Count converter clock periods until the conversion length is reached.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff  <= 10'h000;
            len_ff  <= 10'h000;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (start_i) begin
                cnt_ff  <= 10'h000;
                len_ff  <= conv_len(decim_i);
                busy_ff <= 1'b1;
            end else if (busy_ff && en_ff) begin
                cnt_ff <= cnt_ff + 10'h001;
                if (cnt_ff + 10'h001 == len_ff) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    assign adc_clk_en_o = en_ff;
    assign done_o       = done_ff;
    assign busy_o       = busy_ff;

endmodule

/* File: test/asc_mod_model.sv */
// Modulator stand-in that hands the sequencer a right-aligned sample.
`timescale 1ns/1ps
module asc_mod_model (
    input  wire logic [1:0]  decimation_select_i,
    output logic      [11:0] mod_result_o
);
    // Gives a 9-bit sample only at rate 128, so a wrong rate shows up as zero.
    assign mod_result_o = (decimation_select_i == 2'h1) ? 12'h1a3 : 12'h000;
endmodule

/* File: test/asc_top_sva.sv */
// Port checker for the conversion sequencer.
`timescale 1ns/1ps
`include "asc_consts.svh"
module asc_top_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [1:0]  i2s_dma_req_i,
    input wire logic        conv_start_o,
    input wire logic        conv_busy_o,
    input wire logic        adc_clk_en_o,
    input wire logic        irq_o,
    input wire logic [8:0]  dma_trigger_o,
    input wire logic        any_conversion_trigger_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Five quiet clocks, then the next converter clock enable.
    sequence gap_s; !adc_clk_en_o [*5] ##1 adc_clk_en_o; endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    low_nibble_a: assert property (wb_ack_o && wb_adr_i[11:2] == `ASC_IDX_RES_LOW
        |-> wb_dat_o[3:0] == 4'h0) else $error("low nibble set");
    clk_div_a: assert property (adc_clk_en_o |=> gap_s) else $error("divider off");
    busy_min_a: assert property (conv_start_o |=> conv_busy_o [*8])
        else $error("conversion too short");
    irq_quiet_a: assert property (irq_o |-> !any_conversion_trigger_o
        && dma_trigger_o[6:0] == 7'h00) else $error("trigger on extra");
    any_dma_a: assert property (any_conversion_trigger_o |-> dma_trigger_o != 9'h000)
        else $error("no channel trigger");
    i2s_share_a: assert property (i2s_dma_req_i[0] |=> dma_trigger_o[7])
        else $error("shared trigger lost");
endmodule
bind asc_top asc_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .i2s_dma_req_i(i2s_dma_req_i), .conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o),
    .adc_clk_en_o(adc_clk_en_o), .irq_o(irq_o), .dma_trigger_o(dma_trigger_o),
    .any_conversion_trigger_o(any_conversion_trigger_o));

/* File: test/adc_sequence_control_bench.sv */
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps
`include "asc_consts.svh"
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module adc_sequence_control_bench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, pin = 1'b0, tmr = 1'b0;
    logic [1:0]  i2s   = 2'h0;
    logic [11:0] adr   = 12'h000;
    logic [31:0] dat   = 32'h0;
    logic [31:0] dout, q;
    logic [11:0] mres;
    logic [1:0]  dec, rsel;
    logic [3:0]  mux;
    logic        ack, irq, anyc;
    int          errors = 0, checks = 0, n_any = 0, n_irq = 0, base;
    asc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
        .external_trigger_pin_i(pin), .timer1_ch0_compare_i(tmr), .i2s_dma_req_i(i2s),
        .mod_result_i(mres), .mux_channel_o(mux), .reference_select_o(rsel),
        .decimation_select_o(dec), .conv_start_o(), .conv_busy_o(), .adc_clk_en_o(),
        .irq_o(irq), .dma_trigger_o(), .any_conversion_trigger_o(anyc));
    asc_mod_model u_mod (.decimation_select_i(dec), .mod_result_o(mres));
    // Clock and result counters.
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (anyc === 1'b1) n_any++;
        if (irq === 1'b1) n_irq++;
    end
    // One classic Wishbone cycle; holds the request until ack is sampled.
    task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we  <= w;
        adr <= {i, 2'b00};
        dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dout;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [9:0] i, input logic [7:0] e, input string n);
        bus(1'b0, i, 8'h00);
        `CHK(n, {24'h0, e}, q)
    endtask
    task automatic sw_run;
        bus(1'b1, `ASC_IDX_CTRL1, 8'h73);
        do bus(1'b0, `ASC_IDX_CTRL1, 8'h00); while (q[6] !== 1'b0);
    endtask
    task automatic t_reset;
        rd(`ASC_IDX_CTRL1, 8'h33, "ctrl1");
        rd(`ASC_IDX_SEQ_CFG, 8'h10, "seq_cfg");
        rd(`ASC_IDX_RES_LOW, 8'h00, "low");
        rd(10'h3ff, 8'h00, "unmapped");
        i2s <= 2'h1;
        @(posedge clk_i) i2s <= 2'h0;
    endtask
    task automatic t_sw_seq;
        bus(1'b1, `ASC_IDX_AIN_EN, 8'h05);
        bus(1'b1, `ASC_IDX_SEQ_CFG, 8'h12);
        sw_run;
        `CHK("results", 2, n_any)
        rd(`ASC_IDX_CTRL1, 8'hb3, "eoc set");
        rd(`ASC_IDX_SEQ_CFG, 8'h13, "readback");
        rd(`ASC_IDX_RES_HIGH, 8'hd1, "high");
        rd(`ASC_IDX_RES_LOW, 8'h80, "low");
        rd(`ASC_IDX_CTRL1, 8'h33, "eoc clear");
    endtask
    task automatic t_extra;
        bus(1'b1, `ASC_IDX_EXTRA_CFG, 8'h5e);
        while (n_irq == 0) @(posedge clk_i);
        `CHK("no trigger", 2, n_any)
        `CHK("extra channel", 4'he, mux)
        `CHK("extra reference", 2'h1, rsel)
        rd(`ASC_IDX_SEQ_CFG, 8'h1e, "extra readback");
        rd(`ASC_IDX_RES_HIGH, 8'hd1, "extra high");
    endtask
    task automatic t_empty;
        bus(1'b1, `ASC_IDX_AIN_EN, 8'h00);
        sw_run;
        rd(`ASC_IDX_CTRL1, 8'hb3, "empty eoc");
        rd(`ASC_IDX_SEQ_CFG, 8'h13, "empty readback");
    endtask
    task automatic t_sources(input logic [1:0] k);
        bus(1'b1, `ASC_IDX_AIN_EN, 8'h05);
        bus(1'b1, `ASC_IDX_CTRL1, {2'b00, k, 4'h3});
        base = n_any;
        pin <= (k == `ASC_START_SOURCE_SELECT_EXT);
        tmr <= (k == `ASC_START_SOURCE_SELECT_TIMER);
        @(posedge clk_i) tmr <= 1'b0;
        while (n_any < base + 2) @(posedge clk_i);
        repeat (2000) @(posedge clk_i);
        `CHK("source rerun", (k == `ASC_START_SOURCE_SELECT_FREE), (n_any > base + 2))
        pin <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Main sequence, and a watchdog against hangs.
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_sw_seq;
        t_extra;
        t_empty;
        t_sources(`ASC_START_SOURCE_SELECT_EXT);
        t_sources(`ASC_START_SOURCE_SELECT_TIMER);
        t_sources(`ASC_START_SOURCE_SELECT_FREE);
        give_verdict;
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        errors++;
        give_verdict;
    end
endmodule
